//--- rtl/ssc_consts.svh
`ifndef SSC_CONSTS_SVH
`define SSC_CONSTS_SVH
// Functional notes
// - floating mode strap selects auto detect; probe shared pin after enable; code skips the probe while ramp timing (CTRL bit 1) is on.
// - auto detect with valid incoming clock locks to its rising edges.
// - auto detect without clock: low 200kHz, floating 400kHz, high 1MHz.
// - sensed resistor index picks one of seventeen frequencies, 200-1000kHz.
// - auto detect reads shared pin connection only during start-up.
// - later pin changes ignored until main_supply is cycled.
// - programmed frequency is 8MHz divided by whole N, 8 to 40.
// - non-exact programmed request takes the nearest allowed quotient.
// - read-back reports the quantized divider actually in use.
// - strap high: internal 400kHz driven on shared pin, never probed.
// - strap low: probe on every enable; peer supplies stable 200k-1MHz clock.
// - on clock loss fall back to internal oscillator near last frequency.

// ==================== register map
`define SSC_REG_CTRL 8'h00
`define SSC_REG_FREQ 8'h04
`define SSC_REG_STATUS 8'h08
`define SSC_REG_PERIOD 8'h0C
`define SSC_CTRL_PROG_BIT 0
`define SSC_CTRL_RAMP_BIT 1
`define SSC_CTRL_RESET 2'h0
`define SSC_FREQ_RESET 16'h0190

// ==================== timing
`define SSC_CLK_MHZ 100
`define SSC_STARTUP_NS 20000
`define SSC_STARTUP_CYC ((`SSC_STARTUP_NS*`SSC_CLK_MHZ+999)/1000)
`define SSC_DETECT_NS 8000
`define SSC_DETECT_CYC ((`SSC_DETECT_NS*`SSC_CLK_MHZ+999)/1000)
`define SSC_EXT_MIN_NS 1000
`define SSC_EXT_MIN_CYC ((`SSC_EXT_MIN_NS*`SSC_CLK_MHZ+999)/1000)
`define SSC_EXT_MAX_NS 5000
`define SSC_EXT_MAX_CYC ((`SSC_EXT_MAX_NS*`SSC_CLK_MHZ)/1000)
`define SSC_LOSS_NS 6000
`define SSC_LOSS_CYC ((`SSC_LOSS_NS*`SSC_CLK_MHZ)/1000)
`define SSC_GOOD_EDGES 3

// ==================== divider
`define SSC_REF_MHZ 8
`define SSC_REF_KHZ (`SSC_REF_MHZ*1000)
`define SSC_N_MIN 8
`define SSC_N_MAX 40
`define SSC_N_SPAN (`SSC_N_MAX-`SSC_N_MIN)
`define SSC_N_LOW 40
`define SSC_N_OPEN 20
`define SSC_N_HIGH 8
`define SSC_N_OUT 20
`define SSC_HALF_Q ((`SSC_CLK_MHZ*4)/(`SSC_REF_MHZ*2))
`define SSC_N_NS (1000/`SSC_REF_MHZ)
`define SSC_RES_LAST 16
`define SSC_RES_N {6'h08, 6'h09, 6'h0B, 6'h0C, 6'h0D, 6'h0E, 6'h0F, \
  6'h11, 6'h13, 6'h14, 6'h16, 6'h19, 6'h1B, 6'h1E, 6'h21, 6'h24, 6'h28}
`endif

//--- rtl/ssc_pkg.sv
package ssc_pkg;
  // ==================== digitized strap level
  typedef enum logic [1:0] {
    LVL_LOW = 2'h0,
    LVL_OPEN = 2'h1,
    LVL_HIGH = 2'h2
  } ssc_level_t;

  // ==================== clock source state
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_DET = 5'h02,
    ST_LOCK = 5'h04,
    ST_FREE = 5'h08,
    ST_OUT = 5'h10
  } ssc_state_t;
endpackage

//--- rtl/ssc_link_edge.sv
module ssc_link_edge (
  // clocks and reset
  input wire logic clock,
  input wire logic link_clk,
  input wire logic resetn,
  // rising edge event in the system domain
  output logic edge_p
);
  logic tgl_q;
  logic tgl_d;
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic edge_d;

  // ==================== link domain
  // a toggle survives a stopped link clock; no count lives here
  always_comb begin
    tgl_d = ~tgl_q;
  end

  always_ff @(posedge link_clk or negedge resetn) begin
    if (!resetn) begin
      tgl_q <= 1'b0;
    end else begin
      tgl_q <= tgl_d;
    end
  end

  // ==================== system domain
  always_comb begin
    edge_d = s2_q ^ s3_q;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      edge_p <= 1'b0;
    end else begin
      s1_q <= tgl_q;
      s2_q <= s1_q;
      s3_q <= s2_q;
      edge_p <= edge_d;
    end
  end
endmodule

//--- rtl/ssc_top.sv
`include "ssc_consts.svh"

module ssc_top (
  // system
  input wire logic clock,
  input wire logic resetn,
  // apb slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // digitized straps
  input wire ssc_pkg::ssc_level_t cfg_level,
  input wire ssc_pkg::ssc_level_t pin_level,
  input wire logic pin_res_valid,
  input wire logic [4:0] pin_res_idx,
  // enable pin
  input wire logic en_pin,
  // shared clock line
  input wire logic sync_clk,
  output logic sync_out,
  output logic sync_oe_n,
  // switching clock
  output logic sw_clk,
  output logic sw_locked,
  output logic [5:0] sw_div_n
);
  import ssc_pkg::*;

  localparam logic [101:0] RES_TAB = `SSC_RES_N;

  // ==================== pin synchronisers
  logic [9:0] pin_s1_q;
  logic [9:0] pin_s2_q;
  logic en_s1_q;
  logic en_s2_q;
  logic en_prev_q;
  logic ext_edge;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pin_s1_q <= 10'h040;
      pin_s2_q <= 10'h040;
      en_s1_q <= 1'b0;
      en_s2_q <= 1'b0;
      en_prev_q <= 1'b0;
    end else begin
      pin_s1_q <= {cfg_level, pin_level, pin_res_valid, pin_res_idx};
      pin_s2_q <= pin_s1_q;
      en_s1_q <= en_pin;
      en_s2_q <= en_s1_q;
      en_prev_q <= en_s2_q;
    end
  end

  ssc_link_edge u_edge (
    .clock(clock),
    .link_clk(sync_clk),
    .resetn(resetn),
    .edge_p(ext_edge)
  );

  // ==================== start-up strap capture
  // only resetn (main_supply) reopens the capture window
  logic [11:0] up_cnt_q, up_cnt_d;
  logic started_q, started_d;
  ssc_level_t cfg_q, cfg_d, pin_lvl_q, pin_lvl_d;
  logic res_valid_q, res_valid_d;
  logic [4:0] res_idx_q, res_idx_d;

  always_comb begin
    up_cnt_d = up_cnt_q;
    started_d = started_q;
    cfg_d = cfg_q;
    pin_lvl_d = pin_lvl_q;
    res_valid_d = res_valid_q;
    res_idx_d = res_idx_q;
    if (!started_q) begin
      if (up_cnt_q == 12'(`SSC_STARTUP_CYC - 1)) begin
        started_d = 1'b1;
        cfg_d = ssc_level_t'(pin_s2_q[9:8]);
        pin_lvl_d = ssc_level_t'(pin_s2_q[7:6]);
        res_valid_d = pin_s2_q[5];
        res_idx_d = pin_s2_q[4:0];
      end else begin
        up_cnt_d = up_cnt_q + 12'h001;
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      up_cnt_q <= 12'h000;
      started_q <= 1'b0;
      cfg_q <= LVL_OPEN;
      pin_lvl_q <= LVL_OPEN;
      res_valid_q <= 1'b0;
      res_idx_q <= 5'h00;
    end else begin
      up_cnt_q <= up_cnt_d;
      started_q <= started_d;
      cfg_q <= cfg_d;
      pin_lvl_q <= pin_lvl_d;
      res_valid_q <= res_valid_d;
      res_idx_q <= res_idx_d;
    end
  end

  // ==================== nearest divider for a kHz request
  // one compare per boundary between quotients; a tie keeps the higher rate
  logic [`SSC_N_SPAN-1:0] nearer_slow;
  for (genvar k = 0; k < `SSC_N_SPAN; k++) begin : g_mid
    localparam int NK = `SSC_N_MIN + k;
    assign nearer_slow[k] = ({16'h0000, pwdata[15:0]}
      * 32'(2 * NK * (NK + 1))) < 32'(`SSC_REF_KHZ * (2 * NK + 1));
  end

  // ==================== apb registers
  logic [1:0] ctrl_q, ctrl_d;
  logic [15:0] req_q, req_d;
  logic [5:0] prog_n_q, prog_n_d;
  logic [31:0] prdata_d;
  logic pready_d, pslverr_d;
  logic [5:0] div_q, div_d;
  logic locked_q, locked_d;
  ssc_state_t st_q, st_d;
  logic apb_done, apb_wr;

  assign apb_done = psel & penable & pready;
  assign apb_wr = apb_done & pwrite;

  always_comb begin
    ctrl_d = ctrl_q;
    req_d = req_q;
    prog_n_d = prog_n_q;
    prdata_d = prdata;
    pslverr_d = 1'b0;
    // one wait state: answer in the second access cycle
    pready_d = psel & penable & ~pready;
    if (pready_d) begin
      prdata_d = 32'h0000_0000;
      case (paddr)
        `SSC_REG_CTRL: prdata_d[1:0] = ctrl_q;
        `SSC_REG_FREQ: prdata_d[15:0] = req_q;
        `SSC_REG_STATUS: prdata_d = {16'h0000, 2'h0, div_q, 2'h0,
          pin_lvl_q, cfg_q, locked_q, started_q};
        `SSC_REG_PERIOD: prdata_d = 32'(div_q) * 32'(`SSC_N_NS);
        default: pslverr_d = 1'b1;
      endcase
      if (pwrite) begin
        prdata_d = 32'h0000_0000;
      end
    end
    if (apb_wr) begin
      case (paddr)
        `SSC_REG_CTRL: ctrl_d = pwdata[1:0];
        `SSC_REG_FREQ: begin
          req_d = pwdata[15:0];
          prog_n_d = 6'(`SSC_N_MIN);
          for (int i = 0; i < `SSC_N_SPAN; i++) begin
            prog_n_d = prog_n_d + {5'h00, nearer_slow[i]};
          end
        end
        default: ctrl_d = ctrl_q;
      endcase
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ctrl_q <= `SSC_CTRL_RESET;
      req_q <= `SSC_FREQ_RESET;
      prog_n_q <= 6'(`SSC_N_OPEN);
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      req_q <= req_d;
      prog_n_q <= prog_n_d;
      prdata <= prdata_d;
      pready <= pready_d;
      pslverr <= pslverr_d;
    end
  end

  // ==================== clock source detection
  logic [10:0] win_q, win_d;
  logic [9:0] per_q, per_d;
  logic [1:0] good_q, good_d;
  logic [5:0] meas_n_q, meas_n_d;
  logic lost_q, lost_d;
  logic en_rise, per_ok;
  logic [31:0] meas_w;
  logic [5:0] meas_c;

  assign en_rise = en_s2_q & ~en_prev_q;
  assign per_ok = (per_q >= 10'(`SSC_EXT_MIN_CYC))
    && (per_q <= 10'(`SSC_EXT_MAX_CYC));

  always_comb begin
    meas_w = (32'(per_q) * `SSC_REF_MHZ + `SSC_CLK_MHZ / 2) / `SSC_CLK_MHZ;
    if (meas_w < `SSC_N_MIN) begin
      meas_c = 6'(`SSC_N_MIN);
    end else if (meas_w > `SSC_N_MAX) begin
      meas_c = 6'(`SSC_N_MAX);
    end else begin
      meas_c = meas_w[5:0];
    end
    st_d = st_q;
    win_d = win_q;
    good_d = good_q;
    meas_n_d = meas_n_q;
    lost_d = lost_q;
    per_d = (per_q == 10'h3FF) ? per_q : per_q + 10'h001;
    if (ext_edge) begin
      per_d = 10'h001;
    end
    case (st_q)
      ST_IDLE: begin
        if (started_q && cfg_q == LVL_HIGH) begin
          st_d = ST_OUT;
        end else if (started_q && en_rise) begin
          lost_d = 1'b0;
          win_d = 11'h000;
          good_d = 2'h0;
          // auto detect is skipped while precise ramp timing is on
          if (cfg_q == LVL_LOW || (cfg_q == LVL_OPEN
              && !ctrl_q[`SSC_CTRL_RAMP_BIT])) begin
            st_d = ST_DET;
          end else begin
            st_d = ST_FREE;
          end
        end
      end
      ST_DET: begin
        win_d = win_q + 11'h001;
        if (ext_edge) begin
          good_d = per_ok ? good_q + 2'h1 : 2'h0;
          meas_n_d = meas_c;
        end
        if (ext_edge && per_ok
            && good_q == 2'(`SSC_GOOD_EDGES - 1)) begin
          st_d = ST_LOCK;
        end else if (win_q == 11'(`SSC_DETECT_CYC - 1)) begin
          st_d = ST_FREE;
        end
      end
      ST_LOCK: begin
        if (ext_edge && per_ok) begin
          meas_n_d = meas_c;
        end
        if (per_q >= 10'(`SSC_LOSS_CYC)) begin
          st_d = ST_FREE;
          lost_d = 1'b1;
        end
      end
      ST_FREE: st_d = ST_FREE;
      ST_OUT: st_d = ST_OUT;
      default: st_d = ST_IDLE;
    endcase
    if (!en_s2_q && st_q != ST_OUT) begin
      st_d = ST_IDLE;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st_q <= ST_IDLE;
      win_q <= 11'h000;
      per_q <= 10'h000;
      good_q <= 2'h0;
      meas_n_q <= 6'(`SSC_N_OPEN);
      lost_q <= 1'b0;
    end else begin
      st_q <= st_d;
      win_q <= win_d;
      per_q <= per_d;
      good_q <= good_d;
      meas_n_q <= meas_n_d;
      lost_q <= lost_d;
    end
  end

  // ==================== divider choice and oscillator
  // quarter-cycle accumulator keeps odd N exact on average
  logic [10:0] acc_q, acc_d, thr;
  logic sw_q, sw_d, oe_n_d;
  logic [5:0] strap_n;

  always_comb begin
    if (res_valid_q) begin
      strap_n = (res_idx_q > 5'(`SSC_RES_LAST)) ? RES_TAB[101:96]
        : RES_TAB[6 * res_idx_q +: 6];
    end else begin
      case (pin_lvl_q)
        LVL_LOW: strap_n = 6'(`SSC_N_LOW);
        LVL_HIGH: strap_n = 6'(`SSC_N_HIGH);
        default: strap_n = 6'(`SSC_N_OPEN);
      endcase
    end
    if (st_q == ST_OUT) begin
      div_d = 6'(`SSC_N_OUT);
    end else if (st_q == ST_LOCK || lost_q) begin
      div_d = meas_n_q;
    end else if (ctrl_q[`SSC_CTRL_PROG_BIT]) begin
      div_d = prog_n_q;
    end else if (cfg_q == LVL_OPEN) begin
      div_d = strap_n;
    end else begin
      div_d = 6'(`SSC_N_OPEN);
    end
    thr = 11'(div_q) * 11'(`SSC_HALF_Q);
    acc_d = acc_q + 11'h004;
    sw_d = sw_q;
    if (st_q == ST_LOCK && ext_edge) begin
      acc_d = 11'h000;
      sw_d = 1'b1;
    end else if (acc_d >= thr) begin
      acc_d = acc_d - thr;
      sw_d = ~sw_q;
    end
    locked_d = (st_d == ST_LOCK);
    oe_n_d = (st_d != ST_OUT);
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      div_q <= 6'(`SSC_N_OPEN);
      acc_q <= 11'h000;
      sw_q <= 1'b0;
      locked_q <= 1'b0;
      sync_oe_n <= 1'b1;
      sync_out <= 1'b0;
    end else begin
      div_q <= div_d;
      acc_q <= acc_d;
      sw_q <= sw_d;
      locked_q <= locked_d;
      sync_oe_n <= oe_n_d;
      sync_out <= sw_d;
    end
  end

  assign sw_clk = sw_q;
  assign sw_locked = locked_q;
  assign sw_div_n = div_q;

  // ==================== checks
  out_drive_a: assert property (@(posedge clock) disable iff (!resetn)
    st_q == ST_OUT |=> !sync_oe_n && !sw_locked && st_q == ST_OUT)
    else $error("driver mode lost the shared line");
  auto_probe_a: assert property (@(posedge clock) disable iff (!resetn)
    st_q == ST_IDLE && started_q && en_rise && cfg_q == LVL_OPEN
    && !ctrl_q[`SSC_CTRL_RAMP_BIT] |=> st_q == ST_DET)
    else $error("auto detect did not probe after enable");
  input_probe_a: assert property (@(posedge clock) disable iff (!resetn)
    st_q == ST_IDLE && started_q && en_rise && cfg_q == LVL_LOW
    |=> st_q == ST_DET ##[1:801] st_q != ST_DET)
    else $error("input mode probe did not resolve");
  lock_edge_a: assert property (@(posedge clock) disable iff (!resetn)
    st_q == ST_LOCK && ext_edge |=> sw_clk && acc_q == 11'h000)
    else $error("switching clock not aligned to incoming edge");
  strap_low_a: assert property (@(posedge clock) disable iff (!resetn)
    st_q == ST_FREE && !lost_q && !ctrl_q[`SSC_CTRL_PROG_BIT]
    && cfg_q == LVL_OPEN && !res_valid_q && pin_lvl_q == LVL_LOW
    |=> sw_div_n == 6'h28)
    else $error("low strap did not give 200kHz");
  res_top_a: assert property (@(posedge clock) disable iff (!resetn)
    st_q == ST_FREE && !lost_q && !ctrl_q[`SSC_CTRL_PROG_BIT]
    && cfg_q == LVL_OPEN && res_valid_q && res_idx_q == 5'h10
    |=> sw_div_n == 6'h08)
    else $error("top resistor code did not give 1MHz");
  strap_hold_a: assert property (@(posedge clock) disable iff (!resetn)
    started_q |=> $stable(cfg_q) && $stable(pin_lvl_q)
    && $stable(res_valid_q) && $stable(res_idx_q))
    else $error("straps changed after start-up");
  prog_range_a: assert property (@(posedge clock) disable iff (!resetn)
    apb_wr && paddr == `SSC_REG_FREQ |=> prog_n_q >= 6'h08
    && prog_n_q <= 6'h28)
    else $error("programmed divider out of range");
  prog_near_a: assert property (@(posedge clock) disable iff (!resetn)
    apb_wr && paddr == `SSC_REG_FREQ && pwdata[15:0] == 16'h032A
    |=> prog_n_q == 6'h0A)
    else $error("810kHz did not round to 800kHz");
  period_rb_a: assert property (@(posedge clock) disable iff (!resetn)
    pready_d && !pwrite && paddr == `SSC_REG_PERIOD
    |=> prdata == 32'($past(div_q)) * 32'h7D)
    else $error("period read-back not quantized divider");
  loss_keep_a: assert property (@(posedge clock) disable iff (!resetn)
    st_q == ST_LOCK ##1 st_q == ST_FREE |=> sw_div_n == meas_n_q
    && !sw_locked)
    else $error("fallback frequency not kept after loss");
  apb_wait_a: assert property (@(posedge clock) disable iff (!resetn)
    psel && penable && !pready |=> pready)
    else $error("apb answer late");
endmodule

//--- verif/ssc_peer.sv
// ==================== peer converter on the shared clock line
module ssc_peer (
  // control from the bench
  input wire logic run,
  input wire logic [15:0] period_ns,
  // shared line
  output logic sync_clk
);
  timeunit 1ns;
  timeprecision 1ps;

  // the peer clock stands still low between bursts, so a stale level
  // can never pass for a running clock
  initial begin
    sync_clk = 1'b0;
    #3.7;
    forever begin
      if (run) begin
        sync_clk = 1'b1;
        #(period_ns / 2.0);
        sync_clk = 1'b0;
        #(period_ns / 2.0);
      end else begin
        sync_clk = 1'b0;
        #1;
      end
    end
  end
endmodule

//--- verif/ssc_top_bench.sv
`include "ssc_consts.svh"

module ssc_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import ssc_pkg::*;

  // ==================== signals
  logic clock, resetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  ssc_level_t cfg_level, pin_level;
  logic pin_res_valid, en_pin, sync_out, sync_oe_n, sw_clk, sw_locked;
  logic [4:0] pin_res_idx;
  logic [5:0] sw_div_n;
  logic peer_run, peer_clk, line, prev, sw_prev;
  logic [15:0] peer_ns;
  int mismatches, n_checks, cyc, seed, f, rises, sw_rises;
  logic [32:0] exp_q[$];
  logic [32:0] msk_q[$];
  localparam logic [32:0] m_all = 33'h1FFFFFFFF;
  localparam logic [32:0] m_stat = 33'h100003FCF;
  int lvl_khz[3] = '{200, 400, 1000};
  int fix_khz[5] = '{810, 1000, 0, 200, 65535};
  int res_khz[17] = '{200, 222, 242, 267, 296, 320, 364, 400, 421, 471,
    533, 571, 615, 667, 727, 889, 1000};

  // only the strapped driver may own the line
  assign line = (sync_oe_n === 1'b0) ? sync_out : peer_clk;

  ssc_top uut (.clock(clock), .resetn(resetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cfg_level(cfg_level),
    .pin_level(pin_level), .pin_res_valid(pin_res_valid),
    .pin_res_idx(pin_res_idx), .en_pin(en_pin), .sync_clk(line),
    .sync_out(sync_out), .sync_oe_n(sync_oe_n), .sw_clk(sw_clk),
    .sw_locked(sw_locked), .sw_div_n(sw_div_n));

  ssc_peer peer (.run(peer_run), .period_ns(peer_ns), .sync_clk(peer_clk));

  // ==================== clock and timeout
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  always @(posedge clock) begin
    cyc++;
    if (cyc == 90000) begin
      mismatches++;
      report_and_stop();
    end
  end

  // ==================== checking
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic cmp_bus(input logic [32:0] got, input logic [32:0] e,
                         input logic [32:0] m);
    n_checks++;
    if ((got & m) !== (e & m)) begin
      mismatches++;
      $display("[FAIL] %0t bus got %h exp %h", $time, got & m, e & m);
    end
  endtask

  task automatic cmp_port(input logic [7:0] got, input logic [7:0] e);
    n_checks++;
    if (got !== e) begin
      mismatches++;
      $display("[FAIL] %0t port got %h exp %h", $time, got, e);
    end
  endtask

  // every answer takes the oldest note
  always @(posedge clock) begin
    if (pready === 1'b1) begin
      if (exp_q.size() == 0)
        cmp_bus({pslverr, prdata}, ~{pslverr, prdata}, m_all);
      else
        cmp_bus({pslverr, prdata}, exp_q.pop_front(), msk_q.pop_front());
    end
  end

  function automatic int ad(input int x);
    return (x < 0) ? -x : x;
  endfunction

  // nearest 8MHz/N; a tie keeps the higher frequency
  function automatic logic [5:0] near_n(input int fk);
    int b;
    b = 8;
    for (int n = 9; n <= 40; n++) begin
      if (ad(8000 - fk * n) * b < ad(8000 - fk * b) * n)
        b = n;
    end
    return 6'(b);
  endfunction

  // ==================== drivers (entered just after a rising edge)
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1)
      @(posedge clock);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  task automatic rd(input logic [7:0] a, input logic [32:0] e,
                    input logic [32:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic err);
    exp_q.push_back({err, 32'h0});
    msk_q.push_back(m_all);
    apb(1'b1, a, d);
  endtask

  task automatic rd_per(input logic [5:0] n);
    rd(`SSC_REG_PERIOD, 33'(n) * 33'd125, m_all);
  endtask

  task automatic boot(input ssc_level_t c, input ssc_level_t p,
                      input logic rv, input logic [4:0] ri);
    resetn <= 1'b0;
    en_pin <= 1'b0;
    cfg_level <= c;
    pin_level <= p;
    pin_res_valid <= rv;
    pin_res_idx <= ri;
    repeat (2) @(posedge clock);
    cmp_port({2'h0, sw_div_n}, 8'h14);
    cmp_port({6'h0, sync_oe_n, sw_locked}, 8'h02);
    resetn <= 1'b1;
    repeat (2010) @(posedge clock);
  endtask

  // waits past the whole detect window
  task automatic enable(input logic v);
    en_pin <= v;
    repeat (830) @(posedge clock);
  endtask

  task automatic chk(input logic l, input logic [5:0] n);
    cmp_port({7'h0, sw_locked}, {7'h0, l});
    cmp_port({2'h0, sw_div_n}, {2'h0, n});
  endtask

  // ==================== scenarios
  initial begin
    seed = 32'h0a920410;
    mismatches = 0;
    n_checks = 0;
    cyc = 0;
    resetn = 1'b0;
    {psel, penable, pwrite, en_pin, pin_res_valid, peer_run} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    cfg_level = LVL_OPEN;
    pin_level = LVL_OPEN;
    pin_res_idx = 5'h00;
    peer_ns = 16'd1250;
    @(posedge clock);
    for (int i = 0; i < 3; i++) begin
      boot(LVL_OPEN, ssc_level_t'(i), 1'b0, 5'h00);
      enable(1'b1);
      chk(1'b0, near_n(lvl_khz[i]));
    end
    // a later pin change must not move the latched rate
    pin_level <= LVL_LOW;
    enable(1'b0);
    enable(1'b1);
    chk(1'b0, near_n(1000));
    rd(`SSC_REG_CTRL, 33'h0, m_all);
    rd(`SSC_REG_FREQ, {17'h0, `SSC_FREQ_RESET}, m_all);
    wr(`SSC_REG_PERIOD, 32'h0, 1'b0);
    rd_per(near_n(1000));
    wr(8'h10, 32'hFFFF, 1'b1);
    rd(8'h10, {1'b1, 32'h0}, m_all);
    rd(`SSC_REG_STATUS, {19'h0, 6'h08, 8'h25}, m_stat);
    for (int i = 0; i < 17; i++) begin
      boot(LVL_OPEN, LVL_OPEN, 1'b1, 5'(i));
      enable(1'b1);
      chk(1'b0, near_n(res_khz[i]));
      rd_per(near_n(res_khz[i]));
    end
    wr(`SSC_REG_CTRL, 32'h1, 1'b0);
    rd(`SSC_REG_CTRL, 33'h1, m_all);
    for (int i = 0; i < 12; i++) begin
      f = (i < 5) ? fix_khz[i] : 150 + ($unsigned($random(seed)) % 951);
      wr(`SSC_REG_FREQ, f, 1'b0);
      rd(`SSC_REG_FREQ, 33'(f), m_all);
      rd_per(near_n(f));
    end
    chk(1'b0, near_n(f));
    // lock to an in-range peer, then lose it
    boot(LVL_OPEN, LVL_OPEN, 1'b0, 5'h00);
    peer_run <= 1'b1;
    enable(1'b1);
    chk(1'b1, near_n(800));
    rd(`SSC_REG_STATUS, {19'h0, near_n(800), 8'h17}, m_stat);
    peer_run <= 1'b0;
    repeat (700) @(posedge clock);
    chk(1'b0, near_n(800));
    // a 160 ns line clock is out of range and is not taken
    enable(1'b0);
    peer_ns <= 16'd160;
    peer_run <= 1'b1;
    enable(1'b1);
    chk(1'b0, near_n(400));
    enable(1'b0);
    peer_ns <= 16'd1250;
    wr(`SSC_REG_CTRL, 32'h2, 1'b0);
    enable(1'b1);
    chk(1'b0, near_n(400));
    // input strap probes again on every enable
    boot(LVL_LOW, LVL_OPEN, 1'b0, 5'h00);
    enable(1'b1);
    chk(1'b1, near_n(800));
    enable(1'b0);
    peer_run <= 1'b0;
    enable(1'b1);
    chk(1'b0, near_n(400));
    enable(1'b0);
    peer_run <= 1'b1;
    enable(1'b1);
    chk(1'b1, near_n(800));
    // driver strap: fixed 400 kHz onto the line, no probing
    boot(LVL_HIGH, LVL_OPEN, 1'b0, 5'h00);
    enable(1'b1);
    chk(1'b0, near_n(400));
    cmp_port({7'h0, sync_oe_n}, 8'h00);
    rises = 0;
    sw_rises = 0;
    prev = sync_out;
    sw_prev = sw_clk;
    repeat (1000) begin
      @(posedge clock);
      if (sync_out === 1'b1 && prev === 1'b0)
        rises++;
      if (sw_clk === 1'b1 && sw_prev === 1'b0)
        sw_rises++;
      prev = sync_out;
      sw_prev = sw_clk;
    end
    cmp_port({7'h0, (rises >= 3 && rises <= 5)}, 8'h01);
    cmp_port({7'h0, (sw_rises >= 3 && sw_rises <= 5)}, 8'h01);
    peer_run <= 1'b0;
    repeat (5) @(posedge clock);
    report_and_stop();
  end
endmodule
